// ### arc_analog_model.sv
// arc_analog_model: sample hold and comparator facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module arc_analog_model (
    // clock
    input wire logic ref_clk,
    // eight channel levels
    input wire logic [63:0] ainLevels,
    // sequencer front end
    input wire logic sampleEn,
    input wire logic [2:0] inputChannelSelect,
    input wire logic [7:0] dacTrial,
    output logic cmpAbove = 1'b0
);
    logic [7:0] held_ff = 8'h00;
    always @(posedge ref_clk) begin
        if (sampleEn) held_ff <= ainLevels[inputChannelSelect * 8 +: 8];
        cmpAbove <= held_ff >= dacTrial;
    end
endmodule
`default_nettype wire

// ### arc_pkg.sv
// arc_pkg: constants for the reference and conversion sequencer
`default_nettype none
package arc_pkg;
    // ---------------------------------------------------------------
    // special function register addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'hd8;
    localparam logic [7:0] ADDR_RESULT = 8'hd9;
    localparam logic [7:0] ADDR_REFPROG = 8'hda;
    localparam logic [7:0] ADDR_DONEREQ = 8'hc0;
    // ---------------------------------------------------------------
    // field positions and reset values
    // ---------------------------------------------------------------
    localparam int BIT_BUSY = 4;
    localparam int BIT_CONT = 3;
    localparam int CHAN_MSB = 2;
    localparam int BIT_DONE = 0;
    localparam int LOW_MSB = 3;
    localparam int UP_LSB = 4;
    localparam int UP_MSB = 7;
    localparam logic [7:0] RST_REFPROG = 8'h00;
    localparam logic [7:0] RST_RESULT = 8'h00;
    localparam logic [7:0] SAR_FIRST = 8'h80;
    localparam logic [7:0] SAR_LAST = 8'h01;
    localparam logic [3:0] CODE_ZERO = 4'h0;
    // tap 16 is the upper reference pin itself
    localparam logic [4:0] TAP_UPPER_PIN = 5'h10;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int OSC_PERIOD_NS = 8;
    localparam int MC_OSC_PERIODS = 6;
    localparam int MC_CLKS = (MC_OSC_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] MC_LAST = 3'(MC_CLKS - 1);
    localparam logic [3:0] SAMPLE_MC = 4'h5;
    localparam logic [3:0] PHASE_ONE = 4'h1;
    // ---------------------------------------------------------------
    // sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_WAIT = 5'b00010,
        ST_SAMPLE = 5'b00100,
        ST_CONV = 5'b01000,
        ST_WRES = 5'b10000
    } arc_state_type;
endpackage
`default_nettype wire

// ### arc_props.sv
// arc_props: assertion checker for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module arc_props (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // register bus
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic [7:0] sfrWrData,
    input wire logic sfrRdEn,
    input wire logic [7:0] sfrRdData,
    // front end and status
    input wire logic sampleEn,
    input wire logic [7:0] dacTrial,
    input wire logic [4:0] internalLowerTap,
    input wire logic [4:0] internalUpperTap,
    input wire logic [2:0] inputChannelSelect,
    input wire logic conversionDoneRequest
);
    import arc_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // ----
    // helpers: last program value, cycles since sample start
    // ----
    logic [7:0] refLast_ff;
    logic [7:0] runCnt_ff;
    logic sampleDly_ff;
    wire refWr = sfrWrEn && sfrAddr == ADDR_REFPROG;
    wire startWr = refWr || (sfrWrEn && sfrAddr == ADDR_RESULT);
    wire ctrlWr = sfrWrEn && sfrAddr == ADDR_CTRL;
    wire [2:0] wrChan = sfrWrData[CHAN_MSB:0];
    wire [4:0] upExp = (refLast_ff[7:4] == CODE_ZERO) ? TAP_UPPER_PIN : {1'b0, refLast_ff[7:4]};
    wire [7:0] nxt_refLast = refWr ? sfrWrData : refLast_ff;
    // counter saturates so a stale run never wraps into a match
    wire [7:0] nxt_runCnt = startWr ? 8'h00 : (sampleEn && !sampleDly_ff) ? 8'h01 :
        (runCnt_ff != 8'h00 && runCnt_ff != 8'hff) ? runCnt_ff + 8'h01 : runCnt_ff;
    always_ff @(posedge ref_clk) begin
        refLast_ff <= reset_n ? nxt_refLast : RST_REFPROG;
        runCnt_ff <= reset_n ? nxt_runCnt : 8'h00;
        sampleDly_ff <= reset_n && sampleEn;
    end
    property p_start; refWr |-> ##[2:7] $rose(sampleEn); endproperty
    a_start: assert property (p_start) else $error("no sample after start");
    property p_lowtap; $rose(sampleEn) |-> internalLowerTap == {1'b0, refLast_ff[3:0]}; endproperty
    a_lowtap: assert property (p_lowtap) else $error("lower tap wrong");
    property p_uptap; $rose(sampleEn) |-> internalUpperTap == upExp; endproperty
    a_uptap: assert property (p_uptap) else $error("upper tap wrong");
    property p_samplelen; $fell(sampleEn) && runCnt_ff != 8'h00 |-> runCnt_ff == 8'h1e; endproperty
    a_samplelen: assert property (p_samplelen) else $error("sample length wrong");
    property p_dac; $fell(sampleEn) && runCnt_ff != 8'h00 |-> dacTrial == SAR_FIRST; endproperty
    a_dac: assert property (p_dac) else $error("first trial wrong");
    property p_donetime; $rose(conversionDoneRequest) |-> runCnt_ff == 8'h4e; endproperty
    a_donetime: assert property (p_donetime) else $error("done timing wrong");
    property p_hold;
        conversionDoneRequest && !(sfrWrEn && sfrAddr == ADDR_DONEREQ) |=> conversionDoneRequest;
    endproperty
    a_hold: assert property (p_hold) else $error("done request dropped");
    property p_rdback;
        sfrRdEn && sfrAddr == ADDR_REFPROG ##1 !sfrRdEn |=> sfrRdData == $past(refLast_ff, 2);
    endproperty
    a_rdback: assert property (p_rdback) else $error("program readback wrong");
    property p_chan; ctrlWr ##1 !ctrlWr |=> inputChannelSelect == $past(wrChan, 2); endproperty
    a_chan: assert property (p_chan) else $error("channel select wrong");
    c_done: cover property ($rose(conversionDoneRequest));
    c_abort: cover property (refWr && runCnt_ff != 8'h00);
    c_conv: cover property ($fell(sampleEn) && runCnt_ff == 8'h1e);
endmodule
bind arc_sequencer arc_props u_arc_props (.ref_clk(ref_clk), .reset_n(reset_n), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
    .sampleEn(sampleEn), .dacTrial(dacTrial), .internalLowerTap(internalLowerTap),
    .internalUpperTap(internalUpperTap), .inputChannelSelect(inputChannelSelect),
    .conversionDoneRequest(conversionDoneRequest));
`default_nettype wire

// ### arc_sequencer.sv
// arc_sequencer: reference program register and conversion sequencer
`timescale 1ns/1ps
`default_nettype none
// Operation
// - any reference program write starts conversion
// - write during conversion restarts it fresh
// - start next machine cycle; busy at sample
// - low nibble lower ref, high nibble upper
// - level is lower pin plus code sixteenths
// - code zero selects the matching pin
// - above upper gives ff, below lower 00
// - phases: sample, convert, write result
// - sample connects the selected input channel
// - eight bits decided msb first
// - result loaded in write phase or by a result write
// - timing counted in six-period machine cycles
// - continuous bit repeats conversions until cleared
// - hardware clears busy; writes ignored
// - done request set by hardware, software clears
// - three-bit field picks one of eight inputs
module arc_sequencer (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // special function register bus
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic [7:0] sfrWrData,
    input wire logic sfrRdEn,
    output logic [7:0] sfrRdData,
    // analog front end
    input wire logic cmpAbove,
    output logic sampleEn,
    output logic [2:0] inputChannelSelect,
    output logic [7:0] dacTrial,
    output logic [4:0] internalLowerTap,
    output logic [4:0] internalUpperTap,
    // status
    output logic conversionDoneRequest
);
    import arc_pkg::*;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    arc_state_type state_ff;
    arc_state_type nxt_state;
    logic [2:0] mcCnt_ff;
    logic [3:0] phaseCnt_ff;
    logic [3:0] nxt_phaseCnt;
    logic [7:0] refProg_ff;
    logic [7:0] activeRef_ff;
    logic [7:0] result_ff;
    logic [7:0] nxt_result;
    logic [7:0] sar_ff;
    logic [7:0] nxt_sar;
    logic [7:0] mask_ff;
    logic [7:0] nxt_mask;
    logic contSel_ff;
    logic [2:0] chanSel_ff;
    logic busy_ff;
    logic nxt_busy;
    logic doneReq_ff;
    logic [7:0] rdData_ff;
    logic [7:0] nxt_rdData;
    logic sampleEn_ff;
    logic [4:0] lowerTap_ff;
    logic [4:0] upperTap_ff;
    logic cmpMeta_ff;
    logic cmpSync_ff;

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    wire logic wrCtrl = sfrWrEn && (sfrAddr == ADDR_CTRL);
    wire logic wrResult = sfrWrEn && (sfrAddr == ADDR_RESULT);
    wire logic wrRefProg = sfrWrEn && (sfrAddr == ADDR_REFPROG);
    wire logic wrDoneReq = sfrWrEn && (sfrAddr == ADDR_DONEREQ);
    wire logic startReq = wrRefProg || wrResult;
    wire logic mcEn = (mcCnt_ff == MC_LAST);
    wire logic sarLast = (mask_ff == SAR_LAST);
    wire logic sampleDone = (phaseCnt_ff == SAMPLE_MC);
    wire logic enterWres = (state_ff == ST_CONV) && mcEn && sarLast;
    // end of conversion raises request
    // an abandoned run must not raise the request
    wire logic doneSet = enterWres && !startReq;
    wire logic [7:0] ctrlRead = {3'b000, busy_ff, contSel_ff, chanSel_ff};
    wire logic [7:0] doneRead = {7'b0000000, doneReq_ff};
    wire logic [3:0] lowCode = activeRef_ff[LOW_MSB:0];
    wire logic [3:0] upCode = activeRef_ff[UP_MSB:UP_LSB];
    // tap n is lower pin plus n sixteenths
    // zero code falls back to the pins
    wire logic [4:0] nxtLowerTap = {1'b0, lowCode};
    wire logic [4:0] nxtUpperTap = (upCode == CODE_ZERO) ? TAP_UPPER_PIN : {1'b0, upCode};

    // ---------------------------------------------------------------
    // machine cycle divider
    // ---------------------------------------------------------------
    // six oscillator periods per machine cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            mcCnt_ff <= 3'h0;
        end else if (mcEn) begin
            mcCnt_ff <= 3'h0;
        end else begin
            mcCnt_ff <= mcCnt_ff + 3'h1;
        end
    end

    // ---------------------------------------------------------------
    // comparator synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cmpMeta_ff <= 1'b0;
            cmpSync_ff <= 1'b0;
        end else begin
            cmpMeta_ff <= cmpAbove;
            cmpSync_ff <= cmpMeta_ff;
        end
    end

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_phaseCnt = phaseCnt_ff;
        nxt_sar = sar_ff;
        nxt_mask = mask_ff;
        nxt_busy = busy_ff;
        nxt_result = result_ff;
        if (wrResult) begin
            nxt_result = sfrWrData;
        end
        if (startReq) begin
            nxt_state = ST_WAIT;
            nxt_busy = 1'b0;
        end else if (mcEn) begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_state = ST_IDLE;
                end
                ST_WAIT: begin
                    nxt_state = ST_SAMPLE;
                    nxt_phaseCnt = PHASE_ONE;
                    nxt_busy = 1'b1;
                end
                ST_SAMPLE: begin
                    if (sampleDone) begin
                        nxt_state = ST_CONV;
                        nxt_sar = SAR_FIRST;
                        nxt_mask = SAR_FIRST;
                    end else begin
                        nxt_phaseCnt = phaseCnt_ff + 4'h1;
                    end
                end
                ST_CONV: begin
                    nxt_sar = (cmpSync_ff ? sar_ff : (sar_ff & ~mask_ff)) | (mask_ff >> 1);
                    nxt_mask = mask_ff >> 1;
                    if (sarLast) begin
                        nxt_state = ST_WRES;
                        nxt_busy = 1'b0;
                        nxt_result = cmpSync_ff ? sar_ff : (sar_ff & ~mask_ff);
                    end
                end
                ST_WRES: begin
                    if (contSel_ff) begin
                        nxt_state = ST_SAMPLE;
                        nxt_phaseCnt = PHASE_ONE;
                        nxt_busy = 1'b1;
                    end else begin
                        nxt_state = ST_IDLE;
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                    nxt_busy = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_ff <= ST_IDLE;
            phaseCnt_ff <= 4'h0;
            sar_ff <= 8'h00;
            mask_ff <= 8'h00;
            busy_ff <= 1'b0;
            result_ff <= RST_RESULT;
        end else begin
            state_ff <= nxt_state;
            phaseCnt_ff <= nxt_phaseCnt;
            sar_ff <= nxt_sar;
            mask_ff <= nxt_mask;
            busy_ff <= nxt_busy;
            result_ff <= nxt_result;
        end
    end

    // ---------------------------------------------------------------
    // software registers
    // ---------------------------------------------------------------
    // busy bit is left out of the control write on purpose
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            contSel_ff <= 1'b0;
            chanSel_ff <= 3'h0;
        end else if (wrCtrl) begin
            contSel_ff <= sfrWrData[BIT_CONT];
            chanSel_ff <= sfrWrData[CHAN_MSB:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            refProg_ff <= RST_REFPROG;
        end else if (wrRefProg) begin
            refProg_ff <= sfrWrData;
        end
    end

    // the write applies to the run it starts
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            activeRef_ff <= RST_REFPROG;
        end else if (wrRefProg) begin
            activeRef_ff <= sfrWrData;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            doneReq_ff <= 1'b0;
        end else if (doneSet) begin
            doneReq_ff <= 1'b1;
        end else if (wrDoneReq) begin
            doneReq_ff <= sfrWrData[BIT_DONE];
        end
    end

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    // unmapped addresses read as zero
    always_comb begin
        case (sfrAddr)
            ADDR_CTRL: nxt_rdData = ctrlRead;
            ADDR_RESULT: nxt_rdData = result_ff;
            ADDR_REFPROG: nxt_rdData = refProg_ff;
            ADDR_DONEREQ: nxt_rdData = doneRead;
            default: nxt_rdData = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rdData_ff <= 8'h00;
        end else if (sfrRdEn) begin
            rdData_ff <= nxt_rdData;
        end
    end

    // ---------------------------------------------------------------
    // analog controls
    // ---------------------------------------------------------------
    // taps are registered so the ladder never sees a decode glitch
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sampleEn_ff <= 1'b0;
            lowerTap_ff <= 5'h00;
            upperTap_ff <= TAP_UPPER_PIN;
        end else begin
            sampleEn_ff <= (nxt_state == ST_SAMPLE);
            lowerTap_ff <= nxtLowerTap;
            upperTap_ff <= nxtUpperTap;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign sfrRdData = rdData_ff;
    assign sampleEn = sampleEn_ff;
    assign inputChannelSelect = chanSel_ff;
    assign dacTrial = sar_ff;
    assign internalLowerTap = lowerTap_ff;
    assign internalUpperTap = upperTap_ff;
    assign conversionDoneRequest = doneReq_ff;
endmodule
`default_nettype wire

// ### tb_top.sv
// tb_top: register level tests of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import arc_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic sfrWrEn = 1'b0;
    logic [7:0] sfrWrData = 8'h00;
    logic sfrRdEn = 1'b0;
    wire [7:0] sfrRdData, dacTrial;
    wire cmpAbove, sampleEn, conversionDoneRequest;
    wire [2:0] inputChannelSelect;
    wire [4:0] internalLowerTap, internalUpperTap;
    localparam logic [63:0] LEVELS = 64'hffc396693c811800;
    int failures = 0;
    int checks = 0;
    int n;
    always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    arc_sequencer u_arc_sequencer (.ref_clk(ref_clk), .reset_n(reset_n), .sfrAddr(sfrAddr),
        .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
        .cmpAbove(cmpAbove), .sampleEn(sampleEn), .inputChannelSelect(inputChannelSelect),
        .dacTrial(dacTrial), .internalLowerTap(internalLowerTap),
        .internalUpperTap(internalUpperTap), .conversionDoneRequest(conversionDoneRequest));
    arc_analog_model u_arc_analog_model (.ref_clk(ref_clk), .ainLevels(LEVELS), .sampleEn(sampleEn),
        .inputChannelSelect(inputChannelSelect), .dacTrial(dacTrial), .cmpAbove(cmpAbove));
    task automatic tally_and_finish();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = 1'b1;
        @(negedge ref_clk);
        sfrWrEn = 1'b0;
        // idle edge so back to back writes never retoggle the strobe at once
        @(negedge ref_clk);
    endtask
    // read data is compared two edges on, after it has settled either way
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfrAddr = a;
        sfrRdEn = 1'b1;
        @(negedge ref_clk);
        sfrRdEn = 1'b0;
        @(negedge ref_clk);
        chk(sfrRdData, exp);
    endtask
    task automatic wait_done(output int cnt);
        cnt = 0;
        while (conversionDoneRequest !== 1'b1) begin
            @(negedge ref_clk);
            cnt++;
            if (cnt > 200) begin
                chk(8'(conversionDoneRequest), 8'h01);
                break;
            end
        end
    endtask
    initial begin
        repeat (2) @(negedge ref_clk);
        reset_n = 1'b1;
        rd(ADDR_REFPROG, RST_REFPROG);
        rd(ADDR_RESULT, RST_RESULT);
        rd(ADDR_DONEREQ, 8'h00);
        rd(8'h11, 8'h00);
        wr(ADDR_CTRL, 8'hf2);
        rd(ADDR_CTRL, 8'h02);
        $display("test 1 done");
        for (int ch = 0; ch < 8; ch++) begin
            wr(ADDR_CTRL, 8'(ch));
            wr(ADDR_DONEREQ, 8'h00);
            wr(ADDR_REFPROG, 8'(ch * 17 + 128));
            wait_done(n);
            chk(8'(n >= 78 && n <= 83), 8'h01);
            rd(ADDR_RESULT, LEVELS[ch * 8 +: 8]);
            rd(ADDR_REFPROG, 8'(ch * 17 + 128));
            rd(ADDR_DONEREQ, 8'h01);
            rd(ADDR_CTRL, 8'(ch));
        end
        $display("test 2 done");
        wr(ADDR_DONEREQ, 8'h00);
        wr(ADDR_REFPROG, 8'h0c);
        repeat (20) @(negedge ref_clk);
        wr(ADDR_CTRL, 8'h07);
        rd(ADDR_CTRL, 8'h17);
        repeat (20) @(negedge ref_clk);
        wr(ADDR_REFPROG, 8'h62);
        wait_done(n);
        chk(8'(n >= 78 && n <= 83), 8'h01);
        rd(ADDR_RESULT, 8'hff);
        rd(ADDR_CTRL, 8'h07);
        $display("test 3 done");
        wr(ADDR_DONEREQ, 8'h00);
        wr(ADDR_CTRL, 8'h0b);
        wr(ADDR_REFPROG, 8'h40);
        wait_done(n);
        chk(8'(n >= 78 && n <= 83), 8'h01);
        wr(ADDR_DONEREQ, 8'h00);
        wait_done(n);
        chk(8'(n), 8'h52);
        rd(ADDR_RESULT, 8'h3c);
        wr(ADDR_DONEREQ, 8'h00);
        repeat (20) @(negedge ref_clk);
        wr(ADDR_CTRL, 8'h03);
        wait_done(n);
        wr(ADDR_DONEREQ, 8'h00);
        repeat (120) @(negedge ref_clk);
        chk(8'(conversionDoneRequest), 8'h00);
        rd(ADDR_CTRL, 8'h03);
        $display("test 4 done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
